/* rtl/csss_regs.svh */
// Constants for the clock source and start-up selection block.
`ifndef CSSS_REGS_SVH
`define CSSS_REGS_SVH
// ==========================================================
// Register map
`define CSSS_ADDR_W 4
`define CSSS_OFF_TRIM 4'h0
`define CSSS_OFF_STATUS 4'h1
`define CSSS_OFF_CONTROL 4'h2
`define CSSS_CTL_WAKE_BIT 0
`define CSSS_CTL_HALT_BIT 1
// ==========================================================
// Fuse codes
`define CSSS_SEL_EXT_CLK 4'h0
`define CSSS_SEL_IRC_LO 4'h1
`define CSSS_SEL_IRC_HI 4'h4
`define CSSS_SEL_ERC_LO 4'h5
`define CSSS_SEL_ERC_HI 4'h8
`define CSSS_SEL_LF_XTAL 4'h9
`define CSSS_STARTUP_RESERVED 2'h3
`define CSSS_CAL_ADDR 8'h00
// ==========================================================
// Timing counts
`define CSSS_CYC_6 17'h00006
`define CSSS_CYC_18 17'h00012
`define CSSS_CYC_1K 17'h00400
`define CSSS_CYC_32K 17'h08000
`define CSSS_WDT_4K 17'h01000
`define CSSS_WDT_64K 17'h10000
`endif

/* rtl/csss_pkg.sv */
// Types for the clock source and start-up selection block.
package csss_pkg;
  // ==========================================================
  // Selected clock source.
  typedef enum logic [4:0] {
    CSSS_SRC_EXT_CLK = 5'h01,
    CSSS_SRC_IRC = 5'h02,
    CSSS_SRC_ERC = 5'h04,
    CSSS_SRC_LF_XTAL = 5'h08,
    CSSS_SRC_HF_XTAL = 5'h10
  } csss_src_t;
  // Decoded start-up figures.
  typedef struct packed {
    logic reserved;
    logic [16:0] wake_cycles;
    logic [16:0] reset_wdt_cycles;
  } csss_timing_t;
  // Start-up sequencer states.
  typedef enum logic [3:0] {
    CSSS_ST_RESET_WAIT = 4'h1,
    CSSS_ST_SRC_WAIT = 4'h2,
    CSSS_ST_RUN = 4'h4,
    CSSS_ST_HALT = 4'h8
  } csss_state_t;
endpackage : csss_pkg

/* rtl/csss_decode.sv */
// Fuse decoder for clock source and start-up times.
`include "csss_regs.svh"
module csss_decode (
  input wire logic [3:0] clock_source_select,
  input wire logic [1:0] startup_time_select,
  output csss_pkg::csss_src_t src,
  output csss_pkg::csss_timing_t timing
);
  import csss_pkg::*;
  // ==========================================================
  // Source range decode; fuse bits are 0 when programmed.
  wire is_ext = clock_source_select == `CSSS_SEL_EXT_CLK;
  wire is_irc = clock_source_select >= `CSSS_SEL_IRC_LO &&
                clock_source_select <= `CSSS_SEL_IRC_HI;
  wire is_erc = clock_source_select >= `CSSS_SEL_ERC_LO &&
                clock_source_select <= `CSSS_SEL_ERC_HI;
  wire is_lfx = clock_source_select == `CSSS_SEL_LF_XTAL;
  wire startup_res = startup_time_select == `CSSS_STARTUP_RESERVED;
  wire [16:0] rst_by_startup = (startup_time_select == 2'h0) ? 17'h00000 :
                               (startup_time_select == 2'h1) ? `CSSS_WDT_4K : `CSSS_WDT_64K;

  // Source selection.
  assign src = is_ext ? CSSS_SRC_EXT_CLK : is_irc ? CSSS_SRC_IRC :
               is_erc ? CSSS_SRC_ERC : is_lfx ? CSSS_SRC_LF_XTAL : CSSS_SRC_HF_XTAL;

  // Wake and reset delay tables per source.
  always_comb begin
    timing = '0;
    if (is_lfx) begin
      timing.reserved = startup_res;
      timing.wake_cycles = (startup_time_select == 2'h2) ? `CSSS_CYC_32K : `CSSS_CYC_1K;
      timing.reset_wdt_cycles = (startup_time_select == 2'h0) ? `CSSS_WDT_4K : `CSSS_WDT_64K;
    end else if (is_erc) begin
      timing.wake_cycles = startup_res ? `CSSS_CYC_6 : `CSSS_CYC_18;
      timing.reset_wdt_cycles = startup_res ? `CSSS_WDT_4K : rst_by_startup;
    end else if (is_irc || is_ext) begin
      timing.reserved = startup_res;
      timing.wake_cycles = `CSSS_CYC_6;
      timing.reset_wdt_cycles = rst_by_startup;
    end else begin
      timing.reserved = 1'b1;
      timing.wake_cycles = `CSSS_CYC_6;
      timing.reset_wdt_cycles = `CSSS_WDT_64K;
    end
  end
endmodule : csss_decode

/* rtl/csss_counter.sv */
// Down counter used for both start-up delays.
module csss_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [16:0] load_value,
  input wire logic tick,
  output logic done
);
  // ==========================================================
  // Count register.
  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  assign cnt_d = load ? load_value : (tick && cnt_q != 17'h00000) ? cnt_q - 17'h00001 : cnt_q;
  assign done = cnt_q == 17'h00000 && !load;
  // Holds the remaining count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 17'h00000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : csss_counter

/* rtl/csss_top.sv */
// Clock source selection, start-up sequencing and oscillator trim.
`include "csss_regs.svh"
module csss_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] clock_source_select,
  input wire logic [1:0] startup_time_select,
  input wire logic wdt_osc_tick,
  input wire logic src_clk_tick,
  input wire logic wake_request,
  input wire logic [7:0] cal_byte,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic [7:0] trim_value,
  output logic [7:0] cal_read_addr,
  output logic cpu_run,
  output logic fuse_reserved,
  output csss_pkg::csss_src_t clock_source,
  output logic [2:0] clk_mux_sel,
  output logic [1:0] erc_range,
  output logic [1:0] irc_freq_sel,
  output logic crystal_pins_free
);
  import csss_pkg::*;
  // ==========================================================
  // Fuse decode.
  csss_timing_t timing;
  csss_src_t src;
  csss_decode u_decode (
    .clock_source_select(clock_source_select),
    .startup_time_select(startup_time_select),
    .src(src),
    .timing(timing)
  );

  // Fixed outputs derived from the fuses.
  assign clock_source = src;
  assign fuse_reserved = timing.reserved;
  assign clk_mux_sel = (src == CSSS_SRC_EXT_CLK) ? 3'h0 :
                       (src == CSSS_SRC_IRC) ? 3'h1 :
                       (src == CSSS_SRC_ERC) ? 3'h2 :
                       (src == CSSS_SRC_LF_XTAL) ? 3'h3 : 3'h4;
  assign erc_range = 2'(clock_source_select - `CSSS_SEL_ERC_LO);
  assign irc_freq_sel = 2'(clock_source_select - `CSSS_SEL_IRC_LO);
  assign crystal_pins_free = src == CSSS_SRC_IRC;
  assign cal_read_addr = `CSSS_CAL_ADDR;

  // ==========================================================
  // Start-up sequencer.
  csss_state_t state_q;
  csss_state_t state_d;
  logic in_reset_q;
  logic wdt_load;
  logic src_load;
  logic wdt_done;
  logic src_done;
  logic ctl_wake;
  logic ctl_halt_q;

  csss_counter u_wdt_cnt (
    .clk(clk),
    .rst(rst),
    .load(wdt_load),
    .load_value(timing.reset_wdt_cycles),
    .tick(wdt_osc_tick),
    .done(wdt_done)
  );

  csss_counter u_src_cnt (
    .clk(clk),
    .rst(rst),
    .load(src_load),
    .load_value(timing.wake_cycles),
    .tick(src_clk_tick),
    .done(src_done)
  );

  // Loads happen on leaving reset, when the reset wait ends and on a wake from a halted state.
  assign wdt_load = in_reset_q;
  assign src_load = (state_q == CSSS_ST_RESET_WAIT && wdt_done) ||
                    (state_q == CSSS_ST_HALT && (wake_request || ctl_wake));

  // Next state decode.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CSSS_ST_RESET_WAIT: begin
        if (!in_reset_q && wdt_done) begin
          state_d = CSSS_ST_SRC_WAIT;
        end
      end
      CSSS_ST_SRC_WAIT: begin
        if (src_done) begin
          state_d = CSSS_ST_RUN;
        end
      end
      CSSS_ST_RUN: begin
        if (ctl_halt_q) begin
          state_d = CSSS_ST_HALT;
        end
      end
      CSSS_ST_HALT: begin
        if (wake_request || ctl_wake) begin
          state_d = CSSS_ST_SRC_WAIT;
        end
      end
      default: begin
        state_d = CSSS_ST_RESET_WAIT;
      end
    endcase
  end

  // State register; first cycle after reset loads the watchdog count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= CSSS_ST_RESET_WAIT;
      in_reset_q <= 1'b1;
    end else begin
      state_q <= state_d;
      in_reset_q <= 1'b0;
    end
  end

  assign cpu_run = state_q == CSSS_ST_RUN;

  // ==========================================================
  // Register port.
  logic [7:0] trim_q;
  logic [7:0] trim_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic cal_pending_q;
  wire wr_trim = reg_write && reg_addr == `CSSS_OFF_TRIM;
  wire wr_ctl = reg_write && reg_addr == `CSSS_OFF_CONTROL;
  assign ctl_wake = wr_ctl && reg_wdata[`CSSS_CTL_WAKE_BIT];
  wire ctl_halt = wr_ctl && reg_wdata[`CSSS_CTL_HALT_BIT] && state_q == CSSS_ST_RUN;

  // Trim follows a software write, else the calibration byte just after reset.
  assign trim_d = wr_trim ? reg_wdata : cal_pending_q ? cal_byte : trim_q;
  assign rdata_d = !reg_read ? 8'h00 :
                   (reg_addr == `CSSS_OFF_TRIM) ? trim_q :
                   (reg_addr == `CSSS_OFF_STATUS) ? {3'h0, fuse_reserved, state_q} :
                   8'h00;

  // Trim register, read data and halt request.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_q <= 8'h00;
      cal_pending_q <= 1'b1;
      rdata_q <= 8'h00;
      ctl_halt_q <= 1'b0;
    end else begin
      trim_q <= trim_d;
      cal_pending_q <= 1'b0;
      rdata_q <= rdata_d;
      ctl_halt_q <= ctl_halt;
    end
  end

  // The trim drives the oscillator directly; higher code is faster.
  assign trim_value = trim_q;
  assign reg_rdata = rdata_q;
endmodule : csss_top

/* testbench/csss_osc_model.sv */
// Model of the oscillators and calibration store beside the clock block.
module csss_osc_model #(
  parameter logic [7:0] CAL = 8'h6B
) (
  wdt_run,
  src_run,
  cal_read_addr,
  wdt_osc_tick,
  src_clk_tick,
  cal_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  input wire logic wdt_run;
  input wire logic src_run;
  input wire logic [7:0] cal_read_addr;
  output logic wdt_osc_tick;
  output logic src_clk_tick;
  output logic [7:0] cal_byte;
  // =========================================================
  // Oscillator ticks and stored byte.
  // Each oscillator ticks once per clock while the bench lets it run.
  assign wdt_osc_tick = wdt_run;
  assign src_clk_tick = src_run;
  // Only the calibration location answers; elsewhere the store shows the inverse.
  assign cal_byte = (cal_read_addr == 8'h00) ? CAL : ~CAL;
endmodule : csss_osc_model

/* testbench/csss_top_properties.sv */
// Concurrent checks on the ports of the clock selection block.
module csss_top_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] clock_source_select,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] cal_byte,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] trim_value,
  input wire logic cpu_run,
  input wire logic fuse_reserved,
  input wire csss_pkg::csss_src_t clock_source,
  input wire logic [1:0] erc_range,
  input wire logic [1:0] irc_freq_sel,
  input wire logic crystal_pins_free
);
  timeunit 1ns;
  timeprecision 1ps;
  import csss_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // =========================================================
  // Source decode, trim and start-up checks.
  // The second edge after release follows an untouched first edge.
  sequence s_released;
    $past(rst, 2) && !$past(rst) && !$past(reg_write);
  endsequence
  a_lf_xtal: assert property (clock_source_select == 4'h9 |-> clock_source == CSSS_SRC_LF_XTAL)
    else $error("crystal code gave another source");
  a_erc_range: assert property (clock_source_select inside {[4'h5:4'h8]} |->
    clock_source == CSSS_SRC_ERC && erc_range == 2'(clock_source_select - 4'h5))
    else $error("external RC decode wrong");
  a_irc_freq: assert property (clock_source_select inside {[4'h1:4'h4]} |->
    clock_source == CSSS_SRC_IRC && irc_freq_sel == 2'(clock_source_select - 4'h1))
    else $error("internal RC decode wrong");
  a_ext_clk: assert property (clock_source_select == 4'h0 |-> clock_source == CSSS_SRC_EXT_CLK)
    else $error("external clock not selected");
  a_hf_option: assert property (clock_source_select >= 4'hA |-> fuse_reserved)
    else $error("high-frequency option not flagged");
  a_pins_free: assert property (crystal_pins_free ==
    (clock_source_select inside {[4'h1:4'h4]}))
    else $error("crystal pins freed wrongly");
  a_cal_load: assert property (s_released |-> trim_value == $past(cal_byte))
    else $error("trim not loaded from calibration");
  a_trim_write: assert property (reg_write && reg_addr == 4'h0 |=> trim_value == $past(reg_wdata))
    else $error("trim write lost");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_halt_stop: assert property (reg_write && reg_addr == 4'h2 && reg_wdata[1] && cpu_run |->
    ##[1:3] !cpu_run)
    else $error("halt did not stop the processor");
endmodule : csss_top_properties

bind csss_top csss_top_properties i_csss_top_properties (.clk, .rst, .clock_source_select,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .cal_byte, .reg_rdata, .trim_value, .cpu_run,
  .fuse_reserved, .clock_source, .erc_range, .irc_freq_sel, .crystal_pins_free);

/* testbench/tb.sv */
// Self-checking bench for the clock selection and start-up block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csss_pkg::*;
  localparam logic [7:0] CAL = 8'h6B;
  logic clk = 1'b0, rst = 1'b1, wdt_run = 1'b0, src_run = 1'b0, wake_request = 1'b0;
  logic reg_write = 1'b0, reg_read = 1'b0, wdt_osc_tick, src_clk_tick, cpu_run;
  logic fuse_reserved, crystal_pins_free;
  logic [3:0] clock_source_select = 4'h1, reg_addr = 4'h0;
  logic [1:0] startup_time_select = 2'h0, erc_range, irc_freq_sel;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, trim_value, cal_read_addr, cal_byte;
  logic [2:0] clk_mux_sel;
  csss_src_t clock_source;
  int fail_count = 0, compares = 0, cycles = 0;
  // =========================================================
  // Clock, design and oscillator model.
  // The clock runs at 50 MHz.
  always #10 clk = ~clk;
  csss_top i_csss_top (.clk, .rst, .clock_source_select, .startup_time_select, .wdt_osc_tick,
    .src_clk_tick, .wake_request, .cal_byte, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .trim_value, .cal_read_addr, .cpu_run, .fuse_reserved, .clock_source,
    .clk_mux_sel, .erc_range, .irc_freq_sel, .crystal_pins_free);
  csss_osc_model #(.CAL(CAL)) i_csss_osc_model (.wdt_run, .src_run, .cal_read_addr,
    .wdt_osc_tick, .src_clk_tick, .cal_byte);
  // =========================================================
  // Tasks.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge clk);
  endtask : rd
  // Runs one oscillator for n cycles, then lets the design settle.
  task automatic ticks(input logic wdt, input int n);
    if (n > 0) begin
      wdt_run <= wdt;
      src_run <= !wdt;
      repeat (n) @(posedge clk);
      wdt_run <= 1'b0;
      src_run <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask : ticks
  task automatic wait_run(input int ns);
    ticks(1'b0, ns - 1);
    check({7'h00, cpu_run}, 8'h00);
    ticks(1'b0, 1);
    check({7'h00, cpu_run}, 8'h01);
  endtask : wait_run
  task automatic startup(input logic [3:0] s, input logic [1:0] u, input int nw, input int ns);
    clock_source_select <= s;
    startup_time_select <= u;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    if (nw > 0) begin
      ticks(1'b1, nw - 1);
      ticks(1'b0, ns);
      check({7'h00, cpu_run}, 8'h00);
      ticks(1'b1, 1);
    end
    wait_run(ns);
    $display("start-up test done for code %h/%h", s, u);
  endtask : startup
  // =========================================================
  // Tests and watchdog on the run length.
  initial begin
    startup(4'h1, 2'h0, 0, 6);
    rd(4'h0, CAL);
    // The trim is pushed to its top and then to its bottom by register writes.
    wr(4'h0, 8'hFF);
    check(trim_value, 8'hFF);
    wr(4'h0, 8'h00);
    check(trim_value, 8'h00);
    wr(4'h0, 8'hA5);
    rd(4'h0, 8'hA5);
    wr(4'hF, 8'h5A);
    rd(4'hF, 8'h00);
    check(trim_value, 8'hA5);
    $display("trim test done");
    startup(4'h6, 2'h1, 4096, 18);
    wr(4'h2, 8'h02);
    repeat (4) @(posedge clk);
    rd(4'h1, 8'h08);
    wake_request <= 1'b1;
    @(posedge clk);
    wake_request <= 1'b0;
    wait_run(18);
    rd(4'h1, 8'h04);
    // Halt again and wake through the control register this time.
    wr(4'h2, 8'h02);
    repeat (4) @(posedge clk);
    rd(4'h1, 8'h08);
    wr(4'h2, 8'h01);
    wait_run(18);
    $display("wake test done");
    startup(4'h5, 2'h3, 4096, 6);
    startup(4'h8, 2'h0, 0, 18);
    startup(4'h9, 2'h0, 4096, 1024);
    startup(4'h0, 2'h1, 4096, 6);
    startup(4'h2, 2'h2, 65536, 6);
    startup_time_select <= 2'h3;
    for (int i = 0; i < 16; i++) begin
      clock_source_select <= 4'(i);
      @(posedge clk);
      #1 check({7'h00, fuse_reserved}, {7'h00, !(i inside {[5:8]})});
      check({7'h00, crystal_pins_free}, {7'h00, i inside {[1:4]}});
      check({5'h00, clk_mux_sel},
        (i == 0) ? 8'h00 : (i < 5) ? 8'h01 : (i < 9) ? 8'h02 : (i == 9) ? 8'h03 : 8'h04);
      @(posedge clk);
    end
    $display("decode test done");
    complete_run();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      fail_count++;
      complete_run();
    end
  end
endmodule : tb
